// ===== ccsr_pkg.sv
// Package for the converter configuration and status register slice
package ccsr_pkg;

  localparam int CCSR_ADDR_W = 15;
  localparam int CCSR_DATA_W = 8;

  // Byte addresses of the register map (multi-byte registers span upward)
  localparam logic [14:0] CCSR_EDGE_POS_BASE = 15'h002c;
  localparam logic [14:0] CCSR_FS_CODE_BASE = 15'h0030;
  localparam logic [14:0] CCSR_PWR_MODE_ADDR = 15'h0037;
  localparam logic [14:0] CCSR_TIMESTAMP_INPUT_CONTROL_ADDR = 15'h003b;
  localparam logic [14:0] CCSR_REFO_CTRL_ADDR = 15'h003c;

  // Reset values
  localparam logic [23:0] CCSR_EDGE_POS_RST = 24'h00_0000;
  localparam logic [15:0] CCSR_FS_CODE_RST = 16'ha000;
  localparam logic [7:0] CCSR_PWR_MODE_RST = 8'h4b;
  localparam logic [7:0] CCSR_TIMESTAMP_INPUT_CONTROL_RST = 8'h00;
  localparam logic [7:0] CCSR_REFO_CTRL_RST = 8'h01;

  // Power mode codes
  localparam logic [7:0] CCSR_PWR_LOW = 8'h46;
  localparam logic [7:0] CCSR_PWR_HIGH = 8'h4b;

  // Field positions
  localparam int CCSR_TIMESTAMP_INPUT_RECV_BIT = 0;
  localparam int CCSR_TIMESTAMP_INPUT_PECL_BIT = 1;
  localparam int CCSR_REFO_ON_BIT = 0;

  // One register access from the serial control port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [14:0] addr;
    logic [7:0] wdata;
  } ccsr_req_t;

  // Analog-facing control bundle
  typedef struct packed {
    logic [15:0] full_scale_code;
    logic [7:0] power_mode_code;
    logic power_mode_low;
    logic timestamp_receiver_on;
    logic timestamp_pecl_mode;
    logic reference_output_on;
  } ccsr_ctrl_t;

endpackage

// ===== ccsr_regs.sv
// Configuration and status register bank behind the serial control port
`timescale 1ns/1ps
`default_nettype none

module ccsr_regs (
  input wire logic mclk,
  input wire logic reset,
  input wire ccsr_pkg::ccsr_req_t req,
  input wire logic [23:0] edge_pos_sample,
  input wire logic edge_pos_valid,
  input wire logic pll_enabled,
  output var logic [7:0] rdata,
  output var logic rvalid,
  output var ccsr_pkg::ccsr_ctrl_t ctrl,
  output var logic [23:0] ref_edge_position,
  output var logic reference_output_run
);
  import ccsr_pkg::*;

  logic [23:0] edge_pos_r;
  logic [15:0] fs_code_r;
  logic [7:0] pwr_mode_r;
  logic [7:0] timestamp_input_control_r;
  logic [7:0] refo_ctrl_r;
  logic [7:0] rdata_nxt;
  logic [1:0] pll_sync_r;

  // Address hit within a multi-byte register; returns byte lane or 'hf
  function automatic logic [3:0] lane(input logic [14:0] a, input logic [14:0] base,
                                      input int n);
    logic [14:0] d;
    d = a - base;
    if (a >= base && d < 15'(n)) begin
      return d[3:0];
    end
    return 4'hf;
  endfunction

  // Edge position comes only from the detector, never from the port
  always_ff @(posedge mclk) begin
    if (reset) begin
      edge_pos_r <= CCSR_EDGE_POS_RST;
    end else if (edge_pos_valid) begin
      edge_pos_r <= edge_pos_sample;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      fs_code_r <= CCSR_FS_CODE_RST;
    end else if (req.wr) begin
      if (lane(req.addr, CCSR_FS_CODE_BASE, 2) == 4'h0) begin
        fs_code_r[7:0] <= req.wdata;
      end else if (lane(req.addr, CCSR_FS_CODE_BASE, 2) == 4'h1) begin
        fs_code_r[15:8] <= req.wdata;
      end
    end
  end

  // Reserved codes are stored as written; the analog side sees them as high performance
  always_ff @(posedge mclk) begin
    if (reset) begin
      pwr_mode_r <= CCSR_PWR_MODE_RST;
    end else if (req.wr && req.addr == CCSR_PWR_MODE_ADDR) begin
      pwr_mode_r <= req.wdata;
    end
  end

  // Reserved bits are kept as written so readback matches what software wrote
  always_ff @(posedge mclk) begin
    if (reset) begin
      timestamp_input_control_r <= CCSR_TIMESTAMP_INPUT_CONTROL_RST;
    end else if (req.wr && req.addr == CCSR_TIMESTAMP_INPUT_CONTROL_ADDR) begin
      timestamp_input_control_r <= req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      refo_ctrl_r <= CCSR_REFO_CTRL_RST;
    end else if (req.wr && req.addr == CCSR_REFO_CTRL_ADDR) begin
      refo_ctrl_r <= req.wdata;
    end
  end

  // PLL enable state arrives from the analog domain
  always_ff @(posedge mclk) begin
    if (reset) begin
      pll_sync_r <= 2'b00;
    end else begin
      pll_sync_r <= {pll_sync_r[0], pll_enabled};
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (lane(req.addr, CCSR_EDGE_POS_BASE, 3) != 4'hf) begin
      rdata_nxt = edge_pos_r[8*lane(req.addr, CCSR_EDGE_POS_BASE, 3) +: 8];
    end else if (lane(req.addr, CCSR_FS_CODE_BASE, 2) != 4'hf) begin
      rdata_nxt = fs_code_r[8*lane(req.addr, CCSR_FS_CODE_BASE, 2) +: 8];
    end else if (req.addr == CCSR_PWR_MODE_ADDR) begin
      rdata_nxt = pwr_mode_r;
    end else if (req.addr == CCSR_TIMESTAMP_INPUT_CONTROL_ADDR) begin
      rdata_nxt = timestamp_input_control_r;
    end else if (req.addr == CCSR_REFO_CTRL_ADDR) begin
      rdata_nxt = refo_ctrl_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        rdata <= rdata_nxt;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl <= '{full_scale_code: CCSR_FS_CODE_RST, power_mode_code: CCSR_PWR_MODE_RST,
                power_mode_low: 1'b0, timestamp_receiver_on: 1'b0,
                timestamp_pecl_mode: 1'b0, reference_output_on: 1'b1};
      ref_edge_position <= CCSR_EDGE_POS_RST;
      reference_output_run <= 1'b0;
    end else begin
      ctrl.full_scale_code <= fs_code_r;
      ctrl.power_mode_code <= pwr_mode_r;
      ctrl.power_mode_low <= (pwr_mode_r == CCSR_PWR_LOW);
      ctrl.timestamp_receiver_on <= timestamp_input_control_r[CCSR_TIMESTAMP_INPUT_RECV_BIT];
      ctrl.timestamp_pecl_mode <= timestamp_input_control_r[CCSR_TIMESTAMP_INPUT_PECL_BIT];
      ctrl.reference_output_on <= refo_ctrl_r[CCSR_REFO_ON_BIT];
      ref_edge_position <= edge_pos_r;
      reference_output_run <= refo_ctrl_r[CCSR_REFO_ON_BIT] & pll_sync_r[1];
    end
  end

  property p_edge_hold;
    @(posedge mclk) disable iff (reset) !edge_pos_valid |=> $stable(edge_pos_r);
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge position changed");

  property p_edge_load;
    @(posedge mclk) disable iff (reset)
      edge_pos_valid |=> ##1 ref_edge_position == $past(edge_pos_sample, 2);
  endproperty
  a_edge_load: assert property (p_edge_load) else $error("edge position not captured");

  property p_fs_reset;
    @(posedge mclk) $fell(reset) |->
      fs_code_r == CCSR_FS_CODE_RST && ctrl.full_scale_code == CCSR_FS_CODE_RST;
  endproperty
  a_fs_reset: assert property (p_fs_reset) else $error("full scale reset wrong");

  property p_fs_low_write;
    @(posedge mclk) disable iff (reset)
      req.wr && req.addr == CCSR_FS_CODE_BASE |=> fs_code_r[7:0] == $past(req.wdata)
        ##1 ctrl.full_scale_code[7:0] == $past(req.wdata, 2);
  endproperty
  a_fs_low_write: assert property (p_fs_low_write) else $error("full scale write lost");

  property p_fs_high_write;
    @(posedge mclk) disable iff (reset)
      req.wr && req.addr == CCSR_FS_CODE_BASE + 15'h0001 |=> ##1
        ctrl.full_scale_code[15:8] == $past(req.wdata, 2);
  endproperty
  a_fs_high_write: assert property (p_fs_high_write) else $error("full scale high lost");

  property p_pwr_low;
    @(posedge mclk) disable iff (reset)
      req.wr && req.addr == CCSR_PWR_MODE_ADDR && req.wdata == CCSR_PWR_LOW |=> ##1
        ctrl.power_mode_low;
  endproperty
  a_pwr_low: assert property (p_pwr_low) else $error("low power not selected");

  property p_pwr_high;
    @(posedge mclk) disable iff (reset)
      req.wr && req.addr == CCSR_PWR_MODE_ADDR && req.wdata != CCSR_PWR_LOW |=> ##1
        !ctrl.power_mode_low && ctrl.power_mode_code == $past(req.wdata, 2);
  endproperty
  a_pwr_high: assert property (p_pwr_high) else $error("power code not applied");

  property p_pwr_reset;
    @(posedge mclk) $fell(reset) |-> pwr_mode_r == CCSR_PWR_MODE_RST && !ctrl.power_mode_low;
  endproperty
  a_pwr_reset: assert property (p_pwr_reset) else $error("power mode reset wrong");

  property p_timestamp_input;
    @(posedge mclk) disable iff (reset)
      req.wr && req.addr == CCSR_TIMESTAMP_INPUT_CONTROL_ADDR |=> ##1
        ctrl.timestamp_receiver_on == $past(req.wdata[CCSR_TIMESTAMP_INPUT_RECV_BIT], 2);
  endproperty
  a_timestamp_input: assert property (p_timestamp_input) else $error("receiver enable wrong");

  property p_pecl;
    @(posedge mclk) disable iff (reset)
      req.wr && req.addr == CCSR_TIMESTAMP_INPUT_CONTROL_ADDR |=> ##1
        ctrl.timestamp_pecl_mode == $past(req.wdata[CCSR_TIMESTAMP_INPUT_PECL_BIT], 2);
  endproperty
  a_pecl: assert property (p_pecl) else $error("pecl mode wrong");

  // The output runs exactly when it is switched on and the synchronised PLL enable is high
  property p_refo;
    @(posedge mclk) disable iff (reset)
      reference_output_run == (ctrl.reference_output_on && $past(pll_sync_r[1]));
  endproperty
  a_refo: assert property (p_refo) else $error("reference output gating wrong");

  property p_refo_reset;
    @(posedge mclk) $fell(reset) |-> refo_ctrl_r == CCSR_REFO_CTRL_RST && ctrl.reference_output_on;
  endproperty
  a_refo_reset: assert property (p_refo_reset) else $error("reference output reset wrong");

  c_read: cover property (@(posedge mclk) disable iff (reset) req.rd ##1 rvalid);
  c_low: cover property (@(posedge mclk) disable iff (reset) ctrl.power_mode_low);
  c_edge: cover property (@(posedge mclk) disable iff (reset) edge_pos_valid);
  c_refo: cover property (@(posedge mclk) disable iff (reset) reference_output_run);

endmodule

`default_nettype wire

// ===== ccsr_regs_tb.sv
// Self-checking testbench for the converter configuration register slice
`timescale 1ns/1ps
`default_nettype none

module ccsr_regs_tb;
  import ccsr_pkg::*;
  logic mclk;
  logic reset;
  ccsr_req_t req;
  logic [23:0] edge_pos_sample;
  logic edge_pos_valid;
  logic pll_enabled;
  logic [7:0] rdata;
  logic rvalid;
  ccsr_ctrl_t ctrl;
  logic [23:0] ref_edge_position;
  logic reference_output_run;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  logic [31:0] lfsr;
  logic [15:0] fs_m;
  logic [7:0] pwr_m, ts_m, refo_m;
  logic [23:0] pos_m;
  logic pll_m;

  ccsr_regs ccsr_regs_i (.mclk(mclk), .reset(reset), .req(req),
    .edge_pos_sample(edge_pos_sample), .edge_pos_valid(edge_pos_valid),
    .pll_enabled(pll_enabled), .rdata(rdata), .rvalid(rvalid), .ctrl(ctrl),
    .ref_edge_position(ref_edge_position), .reference_output_run(reference_output_run));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected read byte, little endian for the wide registers
  function automatic logic [7:0] model_rd(input logic [14:0] a);
    case (a)
      CCSR_EDGE_POS_BASE: return pos_m[7:0];
      CCSR_EDGE_POS_BASE + 15'h0001: return pos_m[15:8];
      CCSR_EDGE_POS_BASE + 15'h0002: return pos_m[23:16];
      CCSR_FS_CODE_BASE: return fs_m[7:0];
      CCSR_FS_CODE_BASE + 15'h0001: return fs_m[15:8];
      CCSR_PWR_MODE_ADDR: return pwr_m;
      CCSR_TIMESTAMP_INPUT_CONTROL_ADDR: return ts_m;
      CCSR_REFO_CTRL_ADDR: return refo_m;
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] seen);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Entered just after a rising edge; the second edge lets the registered ctrl outputs follow the write
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(posedge mclk);
    #1 req.wr = 1'b0;
    case (a)
      CCSR_FS_CODE_BASE: fs_m[7:0] = d;
      CCSR_FS_CODE_BASE + 15'h0001: fs_m[15:8] = d;
      CCSR_PWR_MODE_ADDR: pwr_m = d;
      CCSR_TIMESTAMP_INPUT_CONTROL_ADDR: ts_m = d;
      CCSR_REFO_CTRL_ADDR: refo_m = d;
      default: ;
    endcase
    @(posedge mclk);
    #1;
  endtask

  task automatic rd_all();
    for (int a = 'h2c; a <= 'h3e; a++) begin
      req.addr = a[14:0];
      req.rd = 1'b1;
      @(posedge mclk);
      #1 req.rd = 1'b0;
      chk("rvalid", 24'h1, rvalid);
      chk($sformatf("rdata@%h", a), model_rd(a[14:0]),
        rdata);
      @(posedge mclk);
      #1 chk("rvalid_drop", 24'h0, rvalid);
    end
  endtask

  task automatic chk_ctrl();
    chk("fs", fs_m, ctrl.full_scale_code);
    chk("pwr", pwr_m, ctrl.power_mode_code);
    chk("low", pwr_m === CCSR_PWR_LOW, ctrl.power_mode_low);
    chk("recv", ts_m[CCSR_TIMESTAMP_INPUT_RECV_BIT], ctrl.timestamp_receiver_on);
    chk("pecl", ts_m[CCSR_TIMESTAMP_INPUT_PECL_BIT], ctrl.timestamp_pecl_mode);
    chk("refo", refo_m[CCSR_REFO_ON_BIT], ctrl.reference_output_on);
    chk("run", refo_m[CCSR_REFO_ON_BIT] & pll_m, reference_output_run);
    chk("pos", pos_m, ref_edge_position);
  endtask

  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    req = '0;
    edge_pos_sample = 24'h00_0000;
    edge_pos_valid = 1'b0;
    pll_enabled = 1'b0;
    reset = 1'b1;
    lfsr = 32'h0001_5b7b;
    {fs_m, pwr_m, ts_m, refo_m} = {CCSR_FS_CODE_RST, CCSR_PWR_MODE_RST,
      CCSR_TIMESTAMP_INPUT_CONTROL_RST, CCSR_REFO_CTRL_RST};
    pos_m = CCSR_EDGE_POS_RST;
    pll_m = 1'b0;
    repeat (12) @(posedge mclk);
    #1 reset = 1'b0;
    chk_ctrl();
    rd_all();
    // Full-scale ceiling as a hand-picked corner
    wr(CCSR_FS_CODE_BASE, 8'hff);
    wr(CCSR_FS_CODE_BASE + 15'h0001, 8'hff);
    for (int i = 0; i < 24; i++) begin
      lfsr = lfsr_next(lfsr);
      pll_enabled = lfsr[3];
      pll_m = lfsr[3];
      // High byte kept at 0x20 or above so the code never drops below the recommended floor
      wr(CCSR_FS_CODE_BASE + 15'(lfsr[0]),
        lfsr[0] ? (lfsr[15:8] | 8'h20) : lfsr[15:8]);
      // Stands for software that runs at or below 1 GSPS, has cleared the calibration and
      // link enables, sets the companion power registers and calibrates afterwards; those
      // live outside this slice, so only the code itself is written here
      wr(CCSR_PWR_MODE_ADDR, (i % 3 == 0) ? CCSR_PWR_LOW :
        (i % 3 == 1) ? CCSR_PWR_HIGH : lfsr[23:16]);
      // Reserved bits go back at their reset value of zero
      wr(CCSR_TIMESTAMP_INPUT_CONTROL_ADDR, {6'h00, lfsr[21:20]});
      wr(CCSR_REFO_CTRL_ADDR, {7'h00, lfsr[24]});
      wr(CCSR_EDGE_POS_BASE + 15'(lfsr[5:4]), lfsr[7:0]);
      chk_ctrl();
      edge_pos_sample = 24'(lfsr_next(lfsr) >> 4);
      edge_pos_valid = 1'b1;
      @(posedge mclk);
      #1 edge_pos_valid = 1'b0;
      pos_m = edge_pos_sample;
      @(posedge mclk);
      #1 chk("pos_load", pos_m, ref_edge_position);
      rd_all();
    end
    // Mid-run reset: every register and output must return to its reset value
    pll_enabled = 1'b0;
    pll_m = 1'b0;
    reset = 1'b1;
    repeat (2) @(posedge mclk);
    #1 reset = 1'b0;
    {fs_m, pwr_m, ts_m, refo_m} = {CCSR_FS_CODE_RST, CCSR_PWR_MODE_RST,
      CCSR_TIMESTAMP_INPUT_CONTROL_RST, CCSR_REFO_CTRL_RST};
    pos_m = CCSR_EDGE_POS_RST;
    chk_ctrl();
    rd_all();
    end_of_test();
  end
endmodule
`default_nettype wire
